// [logic/pbc_top.v]
// PHY basic control register with its serial management access engine
`timescale 1ns/1ps
`include "pbc_consts.vh"

module pbc_top #(
  parameter [4:0] PHY_ADDR = `PBC_PHY_ADDR_DEF
) (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       mdc,
  input  wire       mdio_in,
  output wire       mdio_out,
  output wire       mdio_oe_n,
  input  wire [1:0] neg_speed,
  input  wire       neg_duplex_full,
  input  wire       tx_active,
  output wire       local_loopback_enable,
  output wire       power_down,
  output wire       mac_side_isolate,
  output wire       autoneg_enable,
  output wire       negotiation_restart,
  output wire       phy_soft_reset,
  output wire [1:0] speed_select,
  output wire       duplex_full,
  output wire       collision_test_enable,
  output wire       collision_out,
  output wire       line_tx_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine states
  localparam [2:0] ST_IDLE  = 3'h0;  // Preamble or idle line
  localparam [2:0] ST_START = 3'h1;  // Seen first start bit
  localparam [2:0] ST_HDR   = 3'h2;  // Opcode, PHY and register address
  localparam [2:0] ST_TA    = 3'h3;  // Turnaround
  localparam [2:0] ST_DATA  = 3'h4;  // Sixteen data bits

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wire [1:0]  sync_pins;           // {mdc, mdio} after two stages
  wire        mdc_s;               // Synchronised clock level
  wire        mdio_s;              // Synchronised data level
  reg         mdc_prev_ff;         // Previous clock level for edge find
  wire        mdc_rise;            // One-cycle rising edge strobe

  reg  [2:0]  state_ff;            // Frame engine state
  reg  [2:0]  nxt_state;
  reg  [3:0]  cnt_ff;              // Bit counter within a field
  reg  [3:0]  nxt_cnt;
  reg  [11:0] hdr_ff;              // {op, phy address, register}
  reg  [11:0] nxt_hdr;
  reg  [15:0] shift_ff;            // Data shifter, both directions
  reg  [15:0] nxt_shift;
  reg         rd_active_ff;        // This frame is our read
  reg         nxt_rd_active;
  reg         mdio_out_ff;         // Data driven onto the pin
  reg         nxt_mdio_out;
  reg         mdio_oe_n_ff;        // Low while driving
  reg         nxt_mdio_oe_n;
  reg         wr_commit;           // Write frame finished for us
  wire [15:0] wr_data;             // Completed write word
  wire [1:0]  hdr_op;              // Frame opcode
  wire [4:0]  hdr_phy;             // Frame PHY address
  wire [4:0]  hdr_reg;             // Frame register index
  reg  [15:0] rd_word;             // Word returned by a read

  reg         loopback_ff;         // Local loopback
  reg  [1:0]  speed_ff;            // Forced speed {upper, lower}
  reg         an_enable_ff;        // Auto-negotiation enable
  reg         power_down_ff;       // General power down
  reg         isolate_ff;          // MAC-side isolation
  reg         duplex_ff;           // Forced duplex
  reg         col_test_ff;         // Collision test
  reg  [5:0]  rsvd_ff;             // Reserved bits, stored only
  reg         an_restart_ff;       // Restart strobe
  reg         soft_reset_ff;       // Soft reset strobe
  reg  [1:0]  eff_speed_ff;        // Speed in force
  reg         eff_duplex_ff;       // Duplex in force
  reg         collision_ff;        // Collision indication
  reg         line_tx_ff;          // Transmit reaches the line
  reg  [15:0] vendor_mem_ff [0:15]; // Vendor-specific registers
  integer     idx;

  ////////////////////////////////////////////////////////////////////////////
  // Address match, used for both read and write decisions
  function addr_hit;
    input [4:0] phy;
    begin
      addr_hit = (phy == PHY_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the pins come from the station manager's domain
  pbc_sync2 u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({mdc, mdio_in}),
    .sync_out (sync_pins)
  );

  assign mdc_s   = sync_pins[1];
  assign mdio_s  = sync_pins[0];
  assign hdr_op  = hdr_ff[11:10];
  assign hdr_phy = hdr_ff[9:5];
  assign hdr_reg = hdr_ff[4:0];
  assign wr_data = {shift_ff[14:0], mdio_s};

  // Edge finder reads only the second stage
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mdc_prev_ff <= 1'b1;
    end else begin
      mdc_prev_ff <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection across the whole space
  always @* begin
    rd_word = 16'h0000;
    if (hdr_reg == `PBC_REG_CONTROL) begin
      // Self-clearing bits always read zero
      rd_word = {1'b0, loopback_ff, speed_ff[0], an_enable_ff, power_down_ff, isolate_ff,
                 1'b0, duplex_ff, col_test_ff, speed_ff[1], rsvd_ff};
    end else if (hdr_reg >= `PBC_REG_VENDOR_FIRST) begin
      rd_word = vendor_mem_ff[hdr_reg[3:0]];
    end else begin
      // Other standard registers live outside this block
      rd_word = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine next state; everything moves on a management clock rise
  always @* begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_hdr       = hdr_ff;
    nxt_shift     = shift_ff;
    nxt_rd_active = rd_active_ff;
    nxt_mdio_out  = mdio_out_ff;
    nxt_mdio_oe_n = mdio_oe_n_ff;
    wr_commit     = 1'b0;
    if (mdc_rise) begin
      case (state_ff)
        ST_IDLE: begin
          // Preamble is optional; the first zero starts a frame
          if (!mdio_s) begin
            nxt_state = ST_START;
          end
        end
        ST_START: begin
          // Second start bit is one; repeated zeros are tolerated
          if (mdio_s) begin
            nxt_state = ST_HDR;
            nxt_cnt   = 4'h0;
          end
        end
        ST_HDR: begin
          nxt_hdr = {hdr_ff[10:0], mdio_s};
          if (cnt_ff == `PBC_HDR_LAST) begin
            nxt_state = ST_TA;
            nxt_cnt   = 4'h0;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        ST_TA: begin
          if (cnt_ff == 4'h0) begin
            nxt_cnt = 4'h1;
            // Second turnaround bit is our driven zero on a read
            if ((hdr_op == `PBC_OP_READ) && addr_hit(hdr_phy)) begin
              nxt_rd_active = 1'b1;
              nxt_mdio_out  = 1'b0;
              nxt_mdio_oe_n = 1'b0;
            end
          end else begin
            nxt_state = ST_DATA;
            nxt_cnt   = 4'h0;
            if (rd_active_ff) begin
              nxt_mdio_out = rd_word[15];
              nxt_shift    = {rd_word[14:0], 1'b0};
            end else begin
              nxt_shift = 16'h0000;
            end
          end
        end
        ST_DATA: begin
          if (rd_active_ff) begin
            nxt_mdio_out = shift_ff[15];
            nxt_shift    = {shift_ff[14:0], 1'b0};
          end else begin
            nxt_shift = wr_data;
          end
          if (cnt_ff == `PBC_DATA_LAST) begin
            // Release the line after the last bit period
            nxt_state     = ST_IDLE;
            nxt_cnt       = 4'h0;
            nxt_rd_active = 1'b0;
            nxt_mdio_out  = 1'b1;
            nxt_mdio_oe_n = 1'b1;
            wr_commit     = ~rd_active_ff & (hdr_op == `PBC_OP_WRITE) & addr_hit(hdr_phy);
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        default: begin
          nxt_state     = ST_IDLE;
          nxt_mdio_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Frame engine registers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 4'h0;
      hdr_ff       <= 12'h000;
      shift_ff     <= 16'h0000;
      rd_active_ff <= 1'b0;
      mdio_out_ff  <= 1'b1;
      mdio_oe_n_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      hdr_ff       <= nxt_hdr;
      shift_ff     <= nxt_shift;
      rd_active_ff <= nxt_rd_active;
      mdio_out_ff  <= nxt_mdio_out;
      mdio_oe_n_ff <= nxt_mdio_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and vendor space updates
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      loopback_ff   <= `PBC_RST_LOOPBACK;
      speed_ff      <= `PBC_RST_SPEED;
      an_enable_ff  <= `PBC_RST_AN_ENABLE;
      power_down_ff <= `PBC_RST_POWER_DOWN;
      isolate_ff    <= `PBC_RST_ISOLATE;
      duplex_ff     <= `PBC_RST_DUPLEX;
      col_test_ff   <= `PBC_RST_COL_TEST;
      rsvd_ff       <= `PBC_RST_RSVD;
      an_restart_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
      for (idx = 0; idx < 16; idx = idx + 1) begin
        vendor_mem_ff[idx] <= `PBC_RST_VENDOR;
      end
    end else begin
      // Strobes last one cycle; the bits read back as zero
      an_restart_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
      if (wr_commit && (hdr_reg == `PBC_REG_CONTROL)) begin
        if (wr_data[`PBC_BIT_SOFT_RESET]) begin
          // Soft reset wins over every other bit of the same write
          soft_reset_ff <= 1'b1;
          loopback_ff   <= `PBC_RST_LOOPBACK;
          speed_ff      <= `PBC_RST_SPEED;
          an_enable_ff  <= `PBC_RST_AN_ENABLE;
          power_down_ff <= `PBC_RST_POWER_DOWN;
          isolate_ff    <= `PBC_RST_ISOLATE;
          duplex_ff     <= `PBC_RST_DUPLEX;
          col_test_ff   <= `PBC_RST_COL_TEST;
          rsvd_ff       <= `PBC_RST_RSVD;
          for (idx = 0; idx < 16; idx = idx + 1) begin
            vendor_mem_ff[idx] <= `PBC_RST_VENDOR;
          end
        end else begin
          loopback_ff   <= wr_data[`PBC_BIT_LOOPBACK];
          speed_ff      <= {wr_data[`PBC_BIT_SPEED_MSB], wr_data[`PBC_BIT_SPEED_LSB]};
          an_enable_ff  <= wr_data[`PBC_BIT_AN_ENABLE];
          power_down_ff <= wr_data[`PBC_BIT_POWER_DOWN];
          isolate_ff    <= wr_data[`PBC_BIT_ISOLATE];
          duplex_ff     <= wr_data[`PBC_BIT_DUPLEX];
          col_test_ff   <= wr_data[`PBC_BIT_COL_TEST];
          // Stored for read-back only, steering nothing
          rsvd_ff       <= wr_data[`PBC_RSVD_MSB:0];
          // Writing zero here does nothing
          an_restart_ff <= wr_data[`PBC_BIT_AN_RESTART];
        end
      end else if (wr_commit && (hdr_reg >= `PBC_REG_VENDOR_FIRST)) begin
        vendor_mem_ff[hdr_reg[3:0]] <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived controls; one cycle behind the register, all from flip-flops
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      eff_speed_ff  <= `PBC_RST_SPEED;
      eff_duplex_ff <= `PBC_RST_DUPLEX;
      collision_ff  <= 1'b0;
      line_tx_ff    <= 1'b0;
    end else begin
      // Negotiated result overrides the forced fields
      if (an_enable_ff) begin
        eff_speed_ff  <= neg_speed;
        eff_duplex_ff <= neg_duplex_full;
      end else begin
        eff_speed_ff  <= speed_ff;
        eff_duplex_ff <= duplex_ff;
      end
      // Collision follows every transmission while testing
      collision_ff <= col_test_ff & tx_active;
      // Loopback or power down keeps transmit off the line
      line_tx_ff   <= tx_active & ~loopback_ff & ~power_down_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign mdio_out              = mdio_out_ff;
  assign mdio_oe_n             = mdio_oe_n_ff;
  assign local_loopback_enable = loopback_ff;
  assign power_down            = power_down_ff;
  assign mac_side_isolate      = isolate_ff;
  assign autoneg_enable        = an_enable_ff;
  assign negotiation_restart   = an_restart_ff;
  assign phy_soft_reset        = soft_reset_ff;
  assign speed_select          = eff_speed_ff;
  assign duplex_full           = eff_duplex_ff;
  assign collision_test_enable = col_test_ff;
  assign collision_out         = collision_ff;
  assign line_tx_enable        = line_tx_ff;

endmodule // pbc_top

// [logic/pbc_consts.vh]
// Constants for the PHY basic control register block and its management frame engine
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH

// Register indices within the 32-entry management space
`define PBC_REG_CONTROL      5'h00
`define PBC_REG_VENDOR_FIRST 5'h10

// Control register field positions
`define PBC_BIT_SOFT_RESET   15
`define PBC_BIT_LOOPBACK     14
`define PBC_BIT_SPEED_LSB    13
`define PBC_BIT_AN_ENABLE    12
`define PBC_BIT_POWER_DOWN   11
`define PBC_BIT_ISOLATE      10
`define PBC_BIT_AN_RESTART   9
`define PBC_BIT_DUPLEX       8
`define PBC_BIT_COL_TEST     7
`define PBC_BIT_SPEED_MSB    6
`define PBC_RSVD_MSB         5

// Control register reset values
`define PBC_RST_LOOPBACK     1'b0
`define PBC_RST_SPEED        2'h2
`define PBC_RST_AN_ENABLE    1'b1
`define PBC_RST_POWER_DOWN   1'b0
`define PBC_RST_ISOLATE      1'b0
`define PBC_RST_DUPLEX       1'b1
`define PBC_RST_COL_TEST     1'b0
`define PBC_RST_RSVD         6'h00
`define PBC_RST_VENDOR       16'h0000

// Speed encodings {upper, lower}
`define PBC_SPEED_10         2'h0
`define PBC_SPEED_100        2'h1
`define PBC_SPEED_1000       2'h2
`define PBC_SPEED_RSVD       2'h3

// Management frame fields and lengths
`define PBC_OP_WRITE         2'h1
`define PBC_OP_READ          2'h2
`define PBC_HDR_LAST         4'hB
`define PBC_DATA_LAST        4'hF
`define PBC_PHY_ADDR_DEF     5'h01

`endif

// [logic/pbc_sync2.v]
// Two-stage synchroniser for the management clock and data pins
`timescale 1ns/1ps

module pbc_sync2 (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire [1:0] async_in,
  output wire [1:0] sync_out
);

  reg [1:0] meta_ff;   // First stage, read only by second stage
  reg [1:0] sync_ff;   // Second stage, safe for logic

  // Both stages idle high like a released open-drain line
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pbc_sync2

// [dv/pbc_mgmt_host.sv]
// Station management host model for the serial management pins
`timescale 1ns/1ps
////////////////////////////////////////
module pbc_mgmt_host (
  input  wire clk_sys,
  input  wire mdio_out,
  input  wire mdio_oe_n,
  output reg  mdc,
  output wire mdio_in
);
  reg host_oe;   // Host drives the data wire
  reg host_bit;  // Host data level
  // Wire level: device first, then host, else the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (host_oe ? host_bit : 1'b1);
  // Clock stands high between frames so the synchronisers see no edge
  initial begin
    mdc      = 1'b1;
    host_oe  = 1'b0;
    host_bit = 1'b1;
  end
  ////////////////////////////////////////
  // One frame plus a released trailing edge; 16 cycles per bit keeps both phases well over 3 cycles
  task frame(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [32:0] vec;  // Start, op, address, register, turnaround, data, idle
    integer    i;
    begin
      vec = {2'h1, op, phy, ra, 2'h2, wd, 1'b1};
      rd  = 16'h0000;
      for (i = 32; i >= 0; i = i - 1) begin
        @(negedge clk_sys);
        mdc      = 1'b0;
        host_oe  = (op == 2'h1 || i > 18) && i > 0;  // Read hands the wire over after the header
        host_bit = vec[i];
        repeat (8) @(negedge clk_sys);
        if (i >= 1 && i <= 16) rd[i-1] = mdio_in;    // Sampled just before the rising edge
        mdc = 1'b1;
        repeat (7) @(negedge clk_sys);
      end
      host_oe = 1'b0;
    end
  endtask
endmodule // pbc_mgmt_host

// [dv/pbc_top_properties.sv]
// Concurrent checks on the ports of the control register block
`timescale 1ns/1ps
module pbc_top_chk (
  input wire       clk_sys,
  input wire       reset_n,
  input wire       mdio_out,
  input wire       mdio_oe_n,
  input wire [1:0] neg_speed,
  input wire       neg_duplex_full,
  input wire       tx_active,
  input wire       local_loopback_enable,
  input wire       power_down,
  input wire       mac_side_isolate,
  input wire       autoneg_enable,
  input wire       negotiation_restart,
  input wire       phy_soft_reset,
  input wire [1:0] speed_select,
  input wire       duplex_full,
  input wire       collision_test_enable,
  input wire       collision_out,
  input wire       line_tx_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Derived outputs lag their causes by one cycle; first edge after reset is skipped
  property p_line_gate;
    $past(reset_n) |-> line_tx_enable == $past(tx_active && !local_loopback_enable && !power_down);
  endproperty
  a_line_gate: assert property (p_line_gate)
    else $error("line transmit enable wrong");
  property p_col_tx;
    $past(reset_n) |-> collision_out == $past(collision_test_enable && tx_active);
  endproperty
  a_col_tx: assert property (p_col_tx)
    else $error("collision output wrong");
  // Soft reset edges are skipped since defaults land around the pulse
  property p_an_speed;
    $past(reset_n) && $past(reset_n, 2) && $past(autoneg_enable) && !$past(phy_soft_reset)
      && !$past(phy_soft_reset, 2) |-> speed_select == $past(neg_speed);
  endproperty
  a_an_speed: assert property (p_an_speed)
    else $error("negotiated speed not in force");
  property p_an_duplex;
    $past(reset_n) && $past(reset_n, 2) && $past(autoneg_enable) && !$past(phy_soft_reset)
      && !$past(phy_soft_reset, 2) |-> duplex_full == $past(neg_duplex_full);
  endproperty
  a_an_duplex: assert property (p_an_duplex)
    else $error("negotiated duplex not in force");
  property p_restart_pulse;
    negotiation_restart |=> !negotiation_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse too long");
  property p_reset_pulse;
    phy_soft_reset |=> !phy_soft_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("soft reset pulse too long");
  property p_soft_defaults;
    phy_soft_reset |-> ##[0:2] (autoneg_enable && !local_loopback_enable && !power_down
      && !mac_side_isolate && !collision_test_enable);
  endproperty
  a_soft_defaults: assert property (p_soft_defaults)
    else $error("fields not back to defaults");
  property p_release_high;
    mdio_oe_n |-> mdio_out;
  endproperty
  a_release_high: assert property (p_release_high)
    else $error("released data pin not high");
endmodule // pbc_top_chk
bind pbc_top pbc_top_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n), .neg_speed(neg_speed), .neg_duplex_full(neg_duplex_full), .tx_active(tx_active),
  .local_loopback_enable(local_loopback_enable), .power_down(power_down), .mac_side_isolate(mac_side_isolate),
  .autoneg_enable(autoneg_enable), .negotiation_restart(negotiation_restart), .phy_soft_reset(phy_soft_reset),
  .speed_select(speed_select), .duplex_full(duplex_full), .collision_test_enable(collision_test_enable),
  .collision_out(collision_out), .line_tx_enable(line_tx_enable));

// [dv/testbench.sv]
// Self-checking bench for the control register block
`timescale 1ns/1ps
module testbench;
  reg         clk_sys;          // 40 MHz clock
  reg         reset_n;          // Active-low reset
  reg  [1:0]  neg_speed;        // Negotiated speed
  reg         neg_duplex_full;  // Negotiated duplex
  reg         tx_active;        // MAC transmitting
  wire        mdc, mdio_in, mdio_out, mdio_oe_n;
  wire        loop_en, pd, iso, an_en, an_rst, srst, col_en, col, line_en, dup;
  wire [1:0]  spd;              // Speed in force
  integer     n_fail, checked, n_an, n_sr, k;
  reg  [15:0] rdat, v;          // Read data, write value
  pbc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .neg_speed(neg_speed), .neg_duplex_full(neg_duplex_full), .tx_active(tx_active),
    .local_loopback_enable(loop_en), .power_down(pd), .mac_side_isolate(iso), .autoneg_enable(an_en),
    .negotiation_restart(an_rst), .phy_soft_reset(srst), .speed_select(spd), .duplex_full(dup),
    .collision_test_enable(col_en), .collision_out(col), .line_tx_enable(line_en));
  pbc_mgmt_host u_host (.clk_sys(clk_sys), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio_in(mdio_in));
  ////////////////////////////////////////
  // Compare tasks: register words and pin groups
  task chk_reg(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input [1:0] got, input [1:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t pins %b expected %b", $time, got, exp);
      end
    end
  endtask
  // Bus tasks over the management frame
  task wr(input [4:0] ra, input [15:0] d);
    u_host.frame(2'h1, 5'h01, ra, d, rdat);
  endtask
  task rd(input [4:0] phy, input [4:0] ra, input [15:0] exp);
    begin
      u_host.frame(2'h2, phy, ra, 16'h0000, rdat);
      chk_reg(rdat, exp);
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Pulse counters, since pulses last one cycle inside a long frame; held in reset so no unknown gets in
  always @(posedge clk_sys) begin
    if (reset_n) begin
      n_an <= n_an + an_rst;
      n_sr <= n_sr + srst;
    end
  end
  // Hang guard well beyond the 27 frames of the sequence
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail = n_fail + 1;
    $display("[FAIL] %0t run did not finish", $time);
    give_verdict;
  end
  ////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    neg_speed = 2'h2;
    neg_duplex_full = 1'b1;
    tx_active = 1'b0;
    {n_fail, checked, n_an, n_sr} = 0;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_pin({an_en, dup}, 2'h3);
    chk_pin({loop_en, pd}, 2'h0);
    chk_pin({iso, col_en}, 2'h0);
    rd(5'h01, 5'h00, 16'h1140);
    // Every forced speed, with loopback and collision test together
    tx_active = 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      v = {2'h1, k[0], 5'h00, 1'b1, k[1], 6'h2A};
      wr(5'h00, v);
      chk_pin(spd, k[1:0]);
      chk_pin({dup, loop_en}, 2'h1);
      chk_pin({col_en, col}, 2'h3);
      chk_pin({line_en, an_en}, 2'h0);
      rd(5'h01, 5'h00, v);
    end
    // Power down and isolate keep management alive
    wr(5'h00, 16'h0D00);
    chk_pin({pd, iso}, 2'h3);
    chk_pin({line_en, col}, 2'h0);
    rd(5'h01, 5'h00, 16'h0D00);
    wr(5'h00, 16'h0100);
    chk_pin({line_en, dup}, 2'h3);
    // Negotiated result overrides the forced fields
    neg_speed = 2'h1;
    neg_duplex_full = 1'b0;
    wr(5'h00, 16'h1140);
    chk_pin(spd, 2'h1);
    chk_pin({dup, an_en}, 2'h1);
    neg_speed = 2'h0;
    repeat (3) @(negedge clk_sys);
    chk_pin(spd, 2'h0);
    wr(5'h00, 16'h1340);
    chk_pin(n_an[1:0], 2'h1);
    rd(5'h01, 5'h00, 16'h1140);
    wr(5'h00, 16'h1140);
    chk_pin(n_an[1:0], 2'h1);
    // Vendor storage, ignored standard index, foreign address
    wr(5'h1F, 16'hA5C3);
    wr(5'h10, 16'h5A3C);
    rd(5'h01, 5'h1F, 16'hA5C3);
    rd(5'h01, 5'h10, 16'h5A3C);
    wr(5'h05, 16'hFFFF);
    rd(5'h01, 5'h05, 16'h0000);
    rd(5'h02, 5'h00, 16'hFFFF);
    // Soft reset restores control and vendor defaults
    tx_active = 1'b0;
    wr(5'h00, 16'h4C00);
    wr(5'h00, 16'hC000);
    chk_pin(n_sr[1:0], 2'h1);
    rd(5'h01, 5'h00, 16'h1140);
    rd(5'h01, 5'h10, 16'h0000);
    give_verdict;
  end
endmodule // testbench
